// ---- src/seiu_top.sv ----
// Status flag, sticky event and interrupt unit with serial register access
`timescale 1ns/1ps
`default_nettype none
`include "seiu_map.svh"

module seiu_top #(
  parameter logic [7:0] DRV_FLAG_SEL = 8'hFF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial register port
  input wire seiu_pkg::seiu_spi_in_type spi_in,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Status sources
  input wire seiu_pkg::seiu_word_type live_status_bits,
  input wire logic driver_reply_ready,
  input wire logic [5:0] aux_event,
  // Interrupt pin
  output logic intr_out
);
  import seiu_pkg::*;

  seiu_state_type st_reg;
  seiu_state_type st_next;
  seiu_word_type set_vec;
  seiu_word_type clr_vec;
  seiu_word_type rd_mux;
  logic [7:0] status_pick;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic frame_done;
  logic is_write;
  logic [6:0] addr;
  seiu_word_type wdata;
  logic [1:0] vel_now;
  logic [1:0] vel_old;
  logic [7:0] drv_now;
  logic [7:0] drv_old;
  logic any_masked;

  // Edges from the second and third synchroniser stages
  assign sck_rise = st_reg.sck_sy[1] & ~st_reg.sck_sy[2];
  assign sck_fall = ~st_reg.sck_sy[1] & st_reg.sck_sy[2];
  assign cs_fall = ~st_reg.cs_sy[1] & st_reg.cs_sy[2];
  assign cs_rise = st_reg.cs_sy[1] & ~st_reg.cs_sy[2];

  // Datagram fields
  assign is_write = st_reg.shift_in[`SEIU_FRAME_WR];
  assign addr = st_reg.shift_in[38:32];
  assign wdata = st_reg.shift_in[31:0];
  assign frame_done = (st_reg.frame == FR_SHIFT) && cs_rise
    && (st_reg.bit_cnt == `SEIU_FRAME_BITS);

  // RQ3 flag change detection
  generate
    for (genvar i = 0; i < `SEIU_EV_GEN_N; i++) begin : g_flag_ev
      assign set_vec[i] = live_status_bits[i] & ~st_reg.flag_prev[i];
    end
  endgenerate

  assign vel_now = live_status_bits[`SEIU_FL_VEL_LSB +: 2];
  assign vel_old = st_reg.flag_prev[`SEIU_FL_VEL_LSB +: 2];
  assign drv_now = live_status_bits[`SEIU_FL_DRV_LSB +: 8] & DRV_FLAG_SEL;
  assign drv_old = st_reg.flag_prev[`SEIU_FL_DRV_LSB +: 8];

  // RQ5 one event per valid velocity code
  assign set_vec[`SEIU_EV_VEL00] = (vel_now == 2'b00) && (vel_old != 2'b00);
  assign set_vec[`SEIU_EV_VEL01] = (vel_now == 2'b01) && (vel_old != 2'b01);
  assign set_vec[`SEIU_EV_VEL10] = (vel_now == 2'b10) && (vel_old != 2'b10);

  // RQ4 single driver event
  assign set_vec[`SEIU_EV_DRV] = |(drv_now & ~drv_old);

  // RQ6 events without a flag
  assign set_vec[`SEIU_EV_REPLY] = driver_reply_ready;
  assign set_vec[31:`SEIU_EV_AUX_LSB] = aux_event;

  // Register read mux
  always_comb begin
    case (addr)
      `SEIU_OFS_GCONF: rd_mux = st_reg.gconf;
      `SEIU_OFS_SSEL: rd_mux = st_reg.ssel;
      `SEIU_OFS_EXEMPT: rd_mux = st_reg.exempt;
      `SEIU_OFS_IMASK: rd_mux = st_reg.imask;
      `SEIU_OFS_EVENTS: rd_mux = st_reg.ev;
      // RQ1 live flags readback
      `SEIU_OFS_FLAGS: rd_mux = live_status_bits;
      default: rd_mux = `SEIU_RST_WORD;
    endcase
  end

  // Clear vector at the end of a datagram
  always_comb begin
    clr_vec = `SEIU_RST_WORD;
    if (frame_done && (addr == `SEIU_OFS_EVENTS)) begin
      if (is_write) begin
        // RQ11 write one to clear
        clr_vec = wdata;
      end else begin
        // RQ7 RQ10 read clear with exemptions
        clr_vec = ~st_reg.exempt;
      end
    end
  end

  // RQ12 RQ13 response status selection
  seiu_status_pick u_pick (
    .ev(st_reg.ev),
    .sel(st_reg.ssel),
    .status(status_pick)
  );

  assign any_masked = |(st_reg.ev & st_reg.imask);

  always_comb begin
    st_next = st_reg;
    st_next.sck_sy = {st_reg.sck_sy[1:0], spi_in.sck};
    st_next.cs_sy = {st_reg.cs_sy[1:0], spi_in.cs_n};
    st_next.sdi_sy = {st_reg.sdi_sy[0], spi_in.sdi};
    st_next.flag_prev = live_status_bits;
    // RQ2 RQ8 RQ18 sticky bits, set beats clear
    st_next.ev = (st_reg.ev & ~clr_vec) | set_vec;
    // RQ14 RQ15 RQ16 masked OR with polarity
    st_next.intr = any_masked ~^ st_reg.gconf[`SEIU_GCONF_INTR_POL];
    case (st_reg.frame)
      FR_IDLE: begin
        if (cs_fall) begin
          st_next.frame = FR_SHIFT;
          st_next.bit_cnt = 6'h00;
          st_next.shift_out = {status_pick, st_reg.rd_data};
          st_next.sdo = status_pick[7];
        end
      end
      FR_SHIFT: begin
        if (cs_rise) begin
          st_next.frame = FR_IDLE;
        end else if (sck_rise) begin
          st_next.shift_in = {st_reg.shift_in[38:0], st_reg.sdi_sy[1]};
          if (st_reg.bit_cnt != 6'h3F) begin
            st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
          end
        // First fall keeps the status MSB loaded at select
        end else if (sck_fall && (st_reg.bit_cnt != 6'h00)) begin
          st_next.shift_out = {st_reg.shift_out[38:0], 1'b0};
          st_next.sdo = st_reg.shift_out[38];
        end
      end
      default: begin
        st_next.frame = FR_IDLE;
      end
    endcase
    if (frame_done) begin
      st_next.rd_data = rd_mux;
      if (is_write) begin
        case (addr)
          `SEIU_OFS_GCONF: st_next.gconf = wdata;
          `SEIU_OFS_SSEL: st_next.ssel = wdata;
          `SEIU_OFS_EXEMPT: st_next.exempt = wdata;
          `SEIU_OFS_IMASK: st_next.imask = wdata;
          default: st_next.gconf = st_reg.gconf;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.sck_sy <= 3'h7;
      st_reg.cs_sy <= 3'h7;
      st_reg.sdi_sy <= 2'h0;
      st_reg.frame <= FR_IDLE;
      st_reg.bit_cnt <= 6'h00;
      st_reg.shift_in <= 40'h00_0000_0000;
      st_reg.shift_out <= 40'h00_0000_0000;
      st_reg.sdo <= 1'b0;
      st_reg.gconf <= `SEIU_RST_WORD;
      st_reg.ssel <= `SEIU_RST_WORD;
      st_reg.exempt <= `SEIU_RST_WORD;
      st_reg.imask <= `SEIU_RST_WORD;
      st_reg.ev <= `SEIU_RST_WORD;
      st_reg.flag_prev <= `SEIU_RST_WORD;
      st_reg.rd_data <= `SEIU_RST_WORD;
      st_reg.intr <= `SEIU_RST_INTR;
    end else begin
      st_reg <= st_next;
    end
  end

  assign spi_sdo = st_reg.sdo;
  assign spi_sdo_oe = (st_reg.frame == FR_SHIFT);
  assign intr_out = st_reg.intr;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // RQ2 no bit falls without a clear
  a_event_sticky_hold: assert property ( // RQ2
    ((~st_reg.ev & $past(st_reg.ev) & ~$past(clr_vec)) == 32'h0000_0000)
  ) else $error("event bit dropped without a clear");

  // RQ3 flag rise sets its event
  a_flag_event_set: assert property ( // RQ3
    (live_status_bits[0] && !st_reg.flag_prev[0]) |=> st_reg.ev[0]
  ) else $error("flag rise did not set event");

  // RQ4 driver event
  a_driver_event_set: assert property ( // RQ4
    (|(drv_now & ~drv_old)) |=> st_reg.ev[`SEIU_EV_DRV]
  ) else $error("driver flag rise did not set driver event");

  // RQ5 velocity code 10 event
  a_vel_code_event: assert property ( // RQ5
    (vel_now == 2'b10 && vel_old != 2'b10) |=> st_reg.ev[`SEIU_EV_VEL10]
  ) else $error("velocity code 10 event missing");

  // RQ6 reply event
  a_reply_event_set: assert property ( // RQ6
    driver_reply_ready |=> st_reg.ev[`SEIU_EV_REPLY]
  ) else $error("reply ready event missing");

  // RQ7 RQ10 read clear keeps only exempt or fresh bits
  a_read_clear_mask: assert property ( // RQ7
    (frame_done && !is_write && addr == `SEIU_OFS_EVENTS)
    |=> ((st_reg.ev & ~$past(st_reg.exempt) & ~$past(set_vec)) == 32'h0000_0000)
  ) else $error("event read left a non-exempt bit set");

  // RQ10 exempt bits survive a read
  a_exempt_kept: assert property ( // RQ10
    (frame_done && !is_write && addr == `SEIU_OFS_EVENTS)
    |=> ((st_reg.ev & $past(st_reg.exempt))
      == (($past(st_reg.ev) | $past(set_vec)) & $past(st_reg.exempt)))
  ) else $error("exempt event cleared by read");

  // RQ11 write one clears
  a_write_one_clear: assert property ( // RQ11
    (frame_done && is_write && addr == `SEIU_OFS_EVENTS)
    |=> ((st_reg.ev & $past(wdata) & ~$past(set_vec)) == 32'h0000_0000)
  ) else $error("written one did not clear event");

  // RQ18 set wins over clear
  a_set_wins_clear: assert property ( // RQ18
    (|set_vec) |=> ((st_reg.ev & $past(set_vec)) == $past(set_vec))
  ) else $error("event set lost against clear");

  // RQ15 RQ16 interrupt level one cycle after masked events and polarity
  a_intr_level_pol: assert property ( // RQ16
    ##2 (intr_out == ($past(any_masked, 1) ~^ $past(st_reg.gconf[`SEIU_GCONF_INTR_POL], 1)))
  ) else $error("interrupt level wrong for mask and polarity");

  // RQ12 status byte leads each response
  a_status_loaded: assert property ( // RQ12
    (st_reg.frame == FR_IDLE && cs_fall)
    |=> (st_reg.shift_out[39:32] == $past(status_pick)) && spi_sdo_oe
  ) else $error("response status byte not loaded");

  // RQ1 flag register readback
  a_flag_readback: assert property ( // RQ1
    (frame_done && !is_write && addr == `SEIU_OFS_FLAGS)
    |=> (st_reg.rd_data == $past(live_status_bits))
  ) else $error("flag readback mismatch");

endmodule : seiu_top
`default_nettype wire

// ---- inc/seiu_map.svh ----
// Offsets, field positions, reset values and counts of the status event unit
// Functional notes
// RQ1: Keep 32 live flags and 32 sticky events, each readable from its own register.
// RQ2: A status change sets its event bit, which stays set until explicitly cleared.
// RQ3: Flags follow the live condition; events record change since the last event read.
// RQ4: One driver event fires when any selected driver flag becomes active.
// RQ5: Two-bit velocity phase has three events, for codes 00, 01 and 10.
// RQ6: Some events have no flag, such as the driver reply ready event.
// RQ7: Reading the event register at 0x0E clears it when the read datagram ends.
// RQ8: Events arising just before or during the read clear may be lost.
// RQ9: Host should read the event register once before regular operation starts.
// RQ10: Bits set in exemption mask 0x0C keep their events across a read.
// RQ11: Writing one to an event bit clears it, exempt bits included.
// RQ12: Up to eight selected events ride in the top bits of every response.
// RQ13: Ones in selection mask 0x0B pick events for the response status bits.
// RQ14: Interrupt pin signals events selected by the 32-bit mask at 0x0D.
// RQ15: Interrupt is the OR of all masked events, active when any is set.
// RQ16: Interrupt is active low, or active high with the polarity bit set.
// RQ17: With more than eight selected, the lowest eight indices go, index 0 first.
// RQ18: A set in the same cycle as a clear wins over the clear.
`ifndef SEIU_MAP_SVH
`define SEIU_MAP_SVH

`define SEIU_OFS_GCONF 7'h00
`define SEIU_OFS_SSEL 7'h0B
`define SEIU_OFS_EXEMPT 7'h0C
`define SEIU_OFS_IMASK 7'h0D
`define SEIU_OFS_EVENTS 7'h0E
`define SEIU_OFS_FLAGS 7'h0F

`define SEIU_GCONF_INTR_POL 29
`define SEIU_RST_WORD 32'h0000_0000
`define SEIU_RST_INTR 1'b1

`define SEIU_FRAME_BITS 6'h28
`define SEIU_FRAME_WR 39
`define SEIU_STATUS_BITS 8

`define SEIU_EV_GEN_N 21
`define SEIU_EV_VEL00 21
`define SEIU_EV_VEL01 22
`define SEIU_EV_VEL10 23
`define SEIU_EV_DRV 24
`define SEIU_EV_REPLY 25
`define SEIU_EV_AUX_LSB 26
`define SEIU_FL_VEL_LSB 21
`define SEIU_FL_DRV_LSB 23

`endif

// ---- inc/seiu_pkg.sv ----
// Types shared by the status event unit
package seiu_pkg;

  typedef logic [31:0] seiu_word_type;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic sdi;
  } seiu_spi_in_type;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b01,
    FR_SHIFT = 2'b10
  } seiu_frame_type;

  typedef struct packed {
    logic [2:0] sck_sy;
    logic [2:0] cs_sy;
    logic [1:0] sdi_sy;
    seiu_frame_type frame;
    logic [5:0] bit_cnt;
    logic [39:0] shift_in;
    logic [39:0] shift_out;
    logic sdo;
    seiu_word_type gconf;
    seiu_word_type ssel;
    seiu_word_type exempt;
    seiu_word_type imask;
    seiu_word_type ev;
    seiu_word_type flag_prev;
    seiu_word_type rd_data;
    logic intr;
  } seiu_state_type;

endpackage : seiu_pkg

// ---- src/seiu_status_pick.sv ----
// Picks the lowest eight selected events for the response status byte
`timescale 1ns/1ps
`default_nettype none
`include "seiu_map.svh"

module seiu_status_pick (
  // Event vector and selection
  input wire seiu_pkg::seiu_word_type ev,
  input wire seiu_pkg::seiu_word_type sel,
  // Packed status, first selected event in bit 0
  output logic [7:0] status
);
  import seiu_pkg::*;

  // RQ17 lowest indices first
  always_comb begin
    logic [3:0] cnt;
    cnt = 4'h0;
    status = 8'h00;
    for (int i = 0; i < 32; i++) begin
      if (sel[i] && (cnt < 4'(`SEIU_STATUS_BITS))) begin
        status[cnt[2:0]] = ev[i];
        cnt = cnt + 4'h1;
      end
    end
  end

endmodule : seiu_status_pick
`default_nettype wire

// ---- tb/seiu_host_model.sv ----
// Host serial master model for the status event unit
`timescale 1ns/1ps
`default_nettype none
module seiu_host_model (
  // Clock
  input wire logic mclk,
  // Serial pins
  output var seiu_pkg::seiu_spi_in_type spi_in,
  input wire logic spi_sdo,
  // Received frame
  output logic [39:0] rx,
  output logic done
);
  import seiu_pkg::*;
  initial begin
    spi_in = '{sck: 1'b1, cs_n: 1'b1, sdi: 1'b0};
    rx = '0;
    done = 1'b0;
  end
  // Mode 3 frame, called at a falling mclk edge
  task automatic xfer(input logic [39:0] f);
    spi_in.cs_n = 1'b0;
    repeat (5) @(negedge mclk);
    for (int i = 39; i >= 0; i--) begin
      spi_in.sck = 1'b0;
      spi_in.sdi = f[i];
      repeat (5) @(negedge mclk);
      rx[i] = spi_sdo;
      spi_in.sck = 1'b1;
      repeat (5) @(negedge mclk);
    end
    spi_in.cs_n = 1'b1;
    spi_in.sdi = ~spi_in.sdi;
    done = 1'b1;
    @(negedge mclk);
    done = 1'b0;
    repeat (8) @(negedge mclk);
  endtask : xfer
endmodule : seiu_host_model
`default_nettype wire

// ---- tb/test_status_event_irq_unit.sv ----
// Self-checking bench for the status event unit
`timescale 1ns/1ps
`default_nettype none
module test_status_event_irq_unit;
  import seiu_pkg::*;
  typedef struct packed {logic [39:0] v; logic dc;} seiu_note_type;
  logic mclk, rst_n, driver_reply_ready, spi_sdo, intr_out, done, prev_dc;
  logic sdo_oe;
  logic [5:0] aux_event;
  logic [39:0] rx, prev;
  seiu_word_type live_status_bits, lv, ev_m, ssel_m, ex_m, im_m, gc_m;
  seiu_spi_in_type spi_in;
  seiu_note_type q[$];
  int n_errors, n_compared;
  logic [6:0] ofs[4] = '{7'h00, 7'h0B, 7'h0C, 7'h0D};
  seiu_top i_dut (.mclk(mclk), .rst_n(rst_n), .spi_in(spi_in), .spi_sdo(spi_sdo),
    .spi_sdo_oe(sdo_oe), .live_status_bits(live_status_bits),
    .driver_reply_ready(driver_reply_ready), .aux_event(aux_event), .intr_out(intr_out));
  seiu_host_model i_host (.mclk(mclk), .spi_in(spi_in), .spi_sdo(spi_sdo), .rx(rx),
    .done(done));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task chk_resp(input string n, input logic [39:0] e, input logic [39:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_resp
  task chk_pin(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk_pin
  task give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  function automatic seiu_word_type rdval(input logic [6:0] a);
    case (a)
      7'h00: return gc_m;
      7'h0B: return ssel_m;
      7'h0C: return ex_m;
      7'h0D: return im_m;
      7'h0E: return ev_m;
      7'h0F: return lv;
      default: return '0;
    endcase
  endfunction : rdval
  function automatic logic [7:0] pick(input seiu_word_type e, input seiu_word_type s);
    int k;
    pick = '0;
    k = 0;
    for (int i = 0; i < 32; i++) if (s[i] && k < 8) begin
      pick[k] = e[i];
      k++;
    end
  endfunction : pick
  // Frame with its expected response noted first
  task frame(input logic w, input logic [6:0] a, input seiu_word_type d);
    q.push_back('{v: {pick(ev_m, ssel_m), prev[31:0]}, dc: prev_dc});
    i_host.xfer({w, a, d});
    prev_dc = 1'b0;
    prev = {8'h00, rdval(a)};
    if (w) begin
      case (a)
        7'h00: gc_m = d;
        7'h0B: ssel_m = d;
        7'h0C: ex_m = d;
        7'h0D: im_m = d;
        7'h0E: ev_m &= ~d;
        default: ;
      endcase
    end else if (a == 7'h0E) ev_m &= ex_m;
  endtask : frame
  task pulse(input logic [5:0] a, input logic r);
    aux_event = a;
    driver_reply_ready = r;
    ev_m |= {a, r, 25'h0};
    @(negedge mclk);
    aux_event = '0;
    driver_reply_ready = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : pulse
  task live(input seiu_word_type v);
    seiu_word_type r;
    r = v & ~lv;
    ev_m |= {11'h0, r[20:0]};
    if (v[22:21] != lv[22:21] && v[22:21] != 2'b11) ev_m[21 + v[22:21]] = 1'b1;
    if (|r[30:23]) ev_m[24] = 1'b1;
    live_status_bits = v;
    lv = v;
    repeat (4) @(negedge mclk);
  endtask : live
  task chk_intr;
    repeat (2) @(negedge mclk);
    chk_pin("intr_out", gc_m[29] ? |(ev_m & im_m) : ~|(ev_m & im_m), intr_out);
    chk_pin("spi_sdo_oe", 1'b0, sdo_oe);
  endtask : chk_intr
  always @(posedge mclk) begin : watch
    seiu_note_type e;
    if (done) begin
      e = q.pop_front();
      chk_pin("spi_sdo_oe", 1'b1, sdo_oe);
      if (e.dc) chk_resp("status", {e.v[39:32], rx[31:0]}, rx);
      else chk_resp("response", e.v, rx);
    end
  end
  initial begin
    repeat (100000) @(negedge mclk);
    n_errors++;
    $display("ERROR watchdog expected end seen none");
    give_verdict;
  end
  initial begin
    rst_n = 1'b0;
    {live_status_bits, lv, ev_m, ssel_m, ex_m, im_m, gc_m, prev} = '0;
    {driver_reply_ready, aux_event} = '0;
    prev_dc = 1'b1;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(88240));
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk_intr;
    frame(1'b0, 7'h0E, '0);
    for (int i = 0; i < 4; i++) begin
      frame(1'b1, ofs[i], $urandom());
      frame(1'b0, ofs[i], '0);
    end
    frame(1'b1, 7'h0F, 32'hFFFF_FFFF);
    frame(1'b0, 7'h2A, '0);
    frame(1'b0, 7'h0F, '0);
    $display("test registers done");
    frame(1'b1, 7'h00, '0);
    frame(1'b1, 7'h0B, 32'hFFFF_FFFF);
    frame(1'b1, 7'h0C, 32'h0800_0000);
    frame(1'b1, 7'h0D, 32'hFFFF_FFFF);
    frame(1'b0, 7'h0E, '0);
    chk_intr;
    pulse(6'h03, 1'b1);
    chk_intr;
    for (int i = 0; i < 3; i++) frame(1'b0, 7'h0E, '0);
    frame(1'b1, 7'h0E, 32'h0800_0000);
    frame(1'b0, 7'h0E, '0);
    frame(1'b0, 7'h0E, '0);
    chk_intr;
    $display("test clearing done");
    live(($urandom() & 32'h001F_FFFF) | 32'h0020_0001);
    live((lv & ~32'h0060_0000) | 32'h0040_0000);
    live((lv & ~32'h0060_0000) | 32'h0180_0000);
    live(lv & ~32'h0080_0000);
    live(lv | 32'h0080_0000);
    live(lv | 32'h0060_0000);
    chk_intr;
    frame(1'b0, 7'h0F, '0);
    frame(1'b0, 7'h0E, '0);
    frame(1'b1, 7'h0B, $urandom());
    pulse(6'h3F, 1'b1);
    frame(1'b0, 7'h0E, '0);
    frame(1'b0, 7'h0E, '0);
    $display("test flags done");
    pulse(6'h01, 1'b0);
    frame(1'b1, 7'h00, 32'h2000_0000);
    chk_intr;
    frame(1'b1, 7'h0D, 32'h0000_0001);
    chk_intr;
    frame(1'b1, 7'h0E, 32'hFFFF_FFFF);
    chk_intr;
    $display("test polarity done");
    give_verdict;
  end
endmodule : test_status_event_irq_unit
`default_nettype wire
